// ===== pmbtf_pkg.sv
// Package: constants, layouts and decode helpers for the tuning/fault block
// Functional notes
// - Shared fault byte: A 5:3, B 2:0
// - Only first fault per channel recorded
// - Fault codes 000b none to 111b overpower
// - Store-all commits fault records to NVM
// - Non-zero fault write: discard, flag, alert
// - Page 00h channel A, 01h channel B
// - Compensation word: gain, tc, ac_path_gain_code, bin
// - Integration gain 2, 1, 0.66, 0.5 times
// - Time constant 5-40us, then 1-8us
// - Ac_path_gain_code 1, 1.5, 2, 0.5 V/V
// - Load line bin indexes 64-entry table
// - Transient word layout, level2 page A only
// - Level2 undershoot 140 to 380 mV, 111b off
// - Minimum off time 45 to 90 ns
// - Blanking 36 ns plus 6 per step
// - Phase-add limit 3 or 4 phases
// - Hysteresis 5 to 20 mV
// - Level1 undershoot 90 to 270 mV, 111b off
// - Current word: input max, boost, offset
// - Low byte output current max, 1 A
// - Input offset 0.1 A steps, signed
package pmbtf_pkg;

  // ----------------------------------------------------------------
  // Command codes and pages
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_COMP = 8'hD7;
  localparam logic [7:0] CMD_FAULT = 8'hD8;
  localparam logic [7:0] CMD_TRANS = 8'hD9;
  localparam logic [7:0] CMD_CURR = 8'hDA;
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLT_A_LSB = 3;
  localparam int FLT_B_LSB = 0;
  localparam int CMP_IGAIN_LSB = 12;
  localparam int CMP_ITC_LSB = 8;
  localparam int CMP_ACG_LSB = 6;
  localparam int CMP_AC_LOAD_LINE_BIN_LSB = 0;
  localparam int TR_UNDERSHOOT_LEVEL2_CODE_LSB = 12;
  localparam int TR_MIN_OFF_TIME_CODE_LSB = 9;
  localparam int TR_BLANK_LSB = 6;
  localparam int TR_PHADD_BIT = 5;
  localparam int TR_HYS_LSB = 3;
  localparam int TR_UNDERSHOOT_LEVEL1_CODE_LSB = 0;
  localparam int CUR_IINMAX_LSB = 8;
  localparam int CUR_BOOST_BIT = 13;
  localparam int CUR_OFS_LSB = 8;
  localparam int CUR_IOUT_LSB = 0;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_OV_OFF = 3'h1;
  localparam logic [2:0] FLT_OV_ON = 3'h2;
  localparam logic [2:0] FLT_IIN_OC = 3'h3;
  localparam logic [2:0] FLT_IOUT_OC = 3'h4;
  localparam logic [2:0] FLT_OT = 3'h5;
  localparam logic [2:0] FLT_PSTAGE = 3'h6;
  localparam logic [2:0] FLT_PIN_OPW = 3'h7;
  localparam logic [3:0] USR_OFF_CODE = 4'h7;
  localparam logic [15:0] RD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PMBTF_LOAD = 2'b00,
    PMBTF_RUN = 2'b01
  } pmbtf_state_e;

  // ----------------------------------------------------------------
  // Stored image
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] intGain;
    logic [3:0] integrationTimeCode;
    logic [1:0] acPathGainCode;
    logic [5:0] acLoadLineBin;
    logic [3:0] undershootLevel2Code;
    logic [1:0] minOffTimeCode;
    logic [2:0] blankingTimeCode;
    logic phaseAddLimit;
    logic [1:0] transientHysteresisCode;
    logic [2:0] undershootLevel1Code;
    logic [7:0] outputCurrentMax;
  } pmbtf_chan_s;

  typedef struct packed {
    pmbtf_chan_s chA;
    pmbtf_chan_s chB;
    logic [7:0] inputCurrentMax;
    logic shuntGainBoost;
    logic [4:0] inputOffsetCode;
    logic [2:0] faultRecordChanA;
    logic [2:0] faultRecordChanB;
  } pmbtf_image_s;

  localparam pmbtf_image_s IMAGE_RST = '0;

  // ----------------------------------------------------------------
  // Decoded settings for the analog loop
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] intGainPct;
    logic [5:0] intTcUs;
    logic [4:0] acGainX10;
    logic usr2Off;
    logic [8:0] usr2Mv;
    logic [6:0] minOffNs;
    logic [6:0] blankNs;
    logic [2:0] phaseMax;
    logic [4:0] hysMv;
    logic usr1Off;
    logic [8:0] usr1Mv;
    logic [7:0] ioutMaxAmp;
  } pmbtf_tune_s;

  function automatic pmbtf_tune_s decodeChan(input pmbtf_chan_s c);
    pmbtf_tune_s t;
    t = '0;
    case (c.intGain)
      2'h0: t.intGainPct = 8'hC8;
      2'h1: t.intGainPct = 8'h64;
      2'h2: t.intGainPct = 8'h42;
      default: t.intGainPct = 8'h32;
    endcase
    if (!c.integrationTimeCode[3]) begin
      t.intTcUs = 6'(5 * (c.integrationTimeCode + 1));
    end else if (c.integrationTimeCode == 4'hC) begin
      t.intTcUs = 6'h05;
    end else begin
      t.intTcUs = 6'({3'h0, c.integrationTimeCode[2:0]} + 1);
    end
    case (c.acPathGainCode)
      2'h0: t.acGainX10 = 5'h0A;
      2'h1: t.acGainX10 = 5'h0F;
      2'h2: t.acGainX10 = 5'h14;
      default: t.acGainX10 = 5'h05;
    endcase
    t.usr2Off = (c.undershootLevel2Code >= USR_OFF_CODE);
    t.usr2Mv = 9'(140 + 40 * c.undershootLevel2Code);
    t.minOffNs = 7'(45 + 15 * c.minOffTimeCode);
    t.blankNs = 7'(36 + 6 * c.blankingTimeCode);
    t.phaseMax = c.phaseAddLimit ? 3'h4 : 3'h3;
    t.hysMv = 5'(5 + 5 * c.transientHysteresisCode);
    t.usr1Off = (c.undershootLevel1Code == 3'h7);
    t.usr1Mv = 9'(90 + 30 * c.undershootLevel1Code);
    t.ioutMaxAmp = c.outputCurrentMax;
    return t;
  endfunction

endpackage

// ===== pmbtf_ac_load_line_bin_rom.sv
// Load line bin table with registered read data
`timescale 1ns/1ns
`default_nettype none
module pmbtf_ac_load_line_bin_rom (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] bin,
  output logic [14:0] loadLineUohm10
);

  logic [14:0] rom [64] = '{
    15'h0000, 15'h04E2, 15'h09C4, 15'h0C35,
    15'h0EA6, 15'h1117, 15'h1388, 15'h15F9,
    15'h186A, 15'h1D4C, 15'h1F21, 15'h1FBD,
    15'h2059, 15'h20F6, 15'h2192, 15'h222E,
    15'h22CA, 15'h2367, 15'h2403, 15'h249F,
    15'h253B, 15'h25D8, 15'h2674, 15'h2710,
    15'h27AC, 15'h2849, 15'h28E5, 15'h2981,
    15'h2BF2, 15'h30D4, 15'h35B6, 15'h3A98,
    15'h3F7A, 15'h445C, 15'h493E, 15'h4BAF,
    15'h4E20, 15'h5091, 15'h5302, 15'h5573,
    15'h57E4, 15'h5CC6, 15'h5E9A, 15'h5F37,
    15'h5FD3, 15'h606F, 15'h610B, 15'h61A8,
    15'h6244, 15'h62E0, 15'h637C, 15'h6419,
    15'h64B5, 15'h6551, 15'h65EA, 15'h668A,
    15'h6726, 15'h67C2, 15'h685E, 15'h68FB,
    15'h6B6C, 15'h704E, 15'h7530, 15'h7A12
  };
  logic [14:0] nxt_data;
  logic [14:0] data_ff;

  always_comb begin
    nxt_data = rom[bin];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_ff <= 15'h0000;
    end else begin
      data_ff <= nxt_data;
    end
  end

  assign loadLineUohm10 = data_ff;

endmodule // pmbtf_ac_load_line_bin_rom
`default_nettype wire

// ===== pmbtf_regs.sv
// Paged tuning and first-fault register bank behind the PMBus engine
`timescale 1ns/1ns
`default_nettype none
module pmbtf_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdPage,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  output logic rdValid,
  input wire logic storeAll,
  input wire pmbtf_pkg::pmbtf_image_s nvmImage,
  output logic nvmStore,
  output pmbtf_pkg::pmbtf_image_s nvmImageOut,
  input wire logic faultEvtA,
  input wire logic [2:0] faultCodeA,
  input wire logic faultEvtB,
  input wire logic [2:0] faultCodeB,
  input wire logic alertClr,
  output logic alertOutputPin,
  output logic cmlInvalidData,
  output logic statusWordCml,
  output pmbtf_pkg::pmbtf_tune_s tuneA,
  output pmbtf_pkg::pmbtf_tune_s tuneB,
  output logic [14:0] acLoadLineA,
  output logic [14:0] acLoadLineB,
  output logic [7:0] inputCurrentMax,
  output logic shuntGainBoost,
  output logic signed [5:0] inputOffsetDeciAmp
);

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  // Flops reset to constants; the NVM image is taken one edge after
  // release so the asynchronous reset never samples a port.
  pmbtf_pkg::pmbtf_state_e state_ff;
  pmbtf_pkg::pmbtf_state_e nxt_state;

  always_comb begin
    case (state_ff)
      pmbtf_pkg::PMBTF_LOAD: nxt_state = pmbtf_pkg::PMBTF_RUN;
      pmbtf_pkg::PMBTF_RUN: nxt_state = pmbtf_pkg::PMBTF_RUN;
      default: nxt_state = pmbtf_pkg::PMBTF_LOAD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= pmbtf_pkg::PMBTF_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic running;
  logic pageA;
  logic pageB;
  logic pageOk;
  logic wrEn;
  logic rdEn;
  logic hitComp;
  logic hitFault;
  logic hitTrans;
  logic hitCurr;
  logic badFaultWr;

  always_comb begin
    running = (state_ff == pmbtf_pkg::PMBTF_RUN);
    pageA = (cmdPage == pmbtf_pkg::PAGE_A);
    pageB = (cmdPage == pmbtf_pkg::PAGE_B);
    pageOk = pageA || pageB;
    wrEn = running && cmdValid && cmdWrite;
    rdEn = running && cmdValid && !cmdWrite;
    hitComp = 1'b0;
    hitFault = 1'b0;
    hitTrans = 1'b0;
    hitCurr = 1'b0;
    if (cmdCode == pmbtf_pkg::CMD_FAULT) begin
      hitFault = 1'b1;
    end else if (cmdCode == pmbtf_pkg::CMD_COMP) begin
      hitComp = pageOk;
    end else if (cmdCode == pmbtf_pkg::CMD_TRANS) begin
      hitTrans = pageOk;
    end else if (cmdCode == pmbtf_pkg::CMD_CURR) begin
      hitCurr = pageOk;
    end
    badFaultWr = wrEn && hitFault && (wrData[7:0] != 8'h00);
  end

  // ----------------------------------------------------------------
  // Configuration image
  // ----------------------------------------------------------------
  pmbtf_pkg::pmbtf_image_s cfg_ff;
  pmbtf_pkg::pmbtf_image_s nxt_cfg;
  pmbtf_pkg::pmbtf_chan_s selCh;
  pmbtf_pkg::pmbtf_chan_s newCh;

  always_comb begin
    selCh = pageB ? cfg_ff.chB : cfg_ff.chA;
    newCh = selCh;
    if (hitComp) begin
      newCh.intGain = wrData[pmbtf_pkg::CMP_IGAIN_LSB +: 2];
      newCh.integrationTimeCode = wrData[pmbtf_pkg::CMP_ITC_LSB +: 4];
      newCh.acPathGainCode = wrData[pmbtf_pkg::CMP_ACG_LSB +: 2];
      newCh.acLoadLineBin = wrData[pmbtf_pkg::CMP_AC_LOAD_LINE_BIN_LSB +: 6];
    end
    if (hitTrans) begin
      if (pageA) begin
        newCh.undershootLevel2Code = wrData[pmbtf_pkg::TR_UNDERSHOOT_LEVEL2_CODE_LSB +: 4];
      end
      newCh.minOffTimeCode = wrData[pmbtf_pkg::TR_MIN_OFF_TIME_CODE_LSB +: 2];
      newCh.blankingTimeCode = wrData[pmbtf_pkg::TR_BLANK_LSB +: 3];
      newCh.phaseAddLimit = wrData[pmbtf_pkg::TR_PHADD_BIT];
      newCh.transientHysteresisCode = wrData[pmbtf_pkg::TR_HYS_LSB +: 2];
      newCh.undershootLevel1Code = wrData[pmbtf_pkg::TR_UNDERSHOOT_LEVEL1_CODE_LSB +: 3];
    end
    if (hitCurr) begin
      newCh.outputCurrentMax = wrData[pmbtf_pkg::CUR_IOUT_LSB +: 8];
    end
  end

  always_comb begin
    nxt_cfg = cfg_ff;
    if (state_ff == pmbtf_pkg::PMBTF_LOAD) begin
      nxt_cfg = nvmImage;
    end else begin
      if (wrEn && (hitComp || hitTrans || hitCurr)) begin
        if (pageB) begin
          nxt_cfg.chB = newCh;
        end else begin
          nxt_cfg.chA = newCh;
        end
      end
      if (wrEn && hitCurr && pageA) begin
        nxt_cfg.inputCurrentMax = wrData[pmbtf_pkg::CUR_IINMAX_LSB +: 8];
      end
      if (wrEn && hitCurr && pageB) begin
        nxt_cfg.shuntGainBoost = wrData[pmbtf_pkg::CUR_BOOST_BIT];
        nxt_cfg.inputOffsetCode = wrData[pmbtf_pkg::CUR_OFS_LSB +: 5];
      end
      // Only an all-zero byte is accepted; it clears both records
      if (wrEn && hitFault && !badFaultWr) begin
        nxt_cfg.faultRecordChanA = pmbtf_pkg::FLT_NONE;
        nxt_cfg.faultRecordChanB = pmbtf_pkg::FLT_NONE;
      end
      // A fault landing with the clearing write is recorded only if that channel's record was already empty
      if (faultEvtA && cfg_ff.faultRecordChanA == pmbtf_pkg::FLT_NONE) begin
        nxt_cfg.faultRecordChanA = faultCodeA;
      end
      if (faultEvtB && cfg_ff.faultRecordChanB == pmbtf_pkg::FLT_NONE) begin
        nxt_cfg.faultRecordChanB = faultCodeB;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= pmbtf_pkg::IMAGE_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved bits, unknown codes and foreign pages read as zero; the fault byte reads on any page
  logic [15:0] nxt_rdData;
  logic nxt_rdValid;
  logic [15:0] rdData_ff;
  logic rdValid_ff;

  always_comb begin
    nxt_rdData = rdData_ff;
    nxt_rdValid = rdEn;
    if (rdEn) begin
      nxt_rdData = pmbtf_pkg::RD_ZERO;
      if (hitFault) begin
        nxt_rdData[pmbtf_pkg::FLT_A_LSB +: 3] = cfg_ff.faultRecordChanA;
        nxt_rdData[pmbtf_pkg::FLT_B_LSB +: 3] = cfg_ff.faultRecordChanB;
      end else if (hitComp) begin
        nxt_rdData[pmbtf_pkg::CMP_IGAIN_LSB +: 2] = selCh.intGain;
        nxt_rdData[pmbtf_pkg::CMP_ITC_LSB +: 4] = selCh.integrationTimeCode;
        nxt_rdData[pmbtf_pkg::CMP_ACG_LSB +: 2] = selCh.acPathGainCode;
        nxt_rdData[pmbtf_pkg::CMP_AC_LOAD_LINE_BIN_LSB +: 6] = selCh.acLoadLineBin;
      end else if (hitTrans) begin
        if (pageA) begin
          nxt_rdData[pmbtf_pkg::TR_UNDERSHOOT_LEVEL2_CODE_LSB +: 4] =
            selCh.undershootLevel2Code;
        end
        nxt_rdData[pmbtf_pkg::TR_MIN_OFF_TIME_CODE_LSB +: 2] = selCh.minOffTimeCode;
        nxt_rdData[pmbtf_pkg::TR_BLANK_LSB +: 3] = selCh.blankingTimeCode;
        nxt_rdData[pmbtf_pkg::TR_PHADD_BIT] = selCh.phaseAddLimit;
        nxt_rdData[pmbtf_pkg::TR_HYS_LSB +: 2] =
          selCh.transientHysteresisCode;
        nxt_rdData[pmbtf_pkg::TR_UNDERSHOOT_LEVEL1_CODE_LSB +: 3] = selCh.undershootLevel1Code;
      end else if (hitCurr) begin
        nxt_rdData[pmbtf_pkg::CUR_IOUT_LSB +: 8] = selCh.outputCurrentMax;
        if (pageA) begin
          nxt_rdData[pmbtf_pkg::CUR_IINMAX_LSB +: 8] = cfg_ff.inputCurrentMax;
        end else begin
          nxt_rdData[pmbtf_pkg::CUR_BOOST_BIT] = cfg_ff.shuntGainBoost;
          nxt_rdData[pmbtf_pkg::CUR_OFS_LSB +: 5] = cfg_ff.inputOffsetCode;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_ff <= pmbtf_pkg::RD_ZERO;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;

  // ----------------------------------------------------------------
  // Invalid data flags and alert
  // ----------------------------------------------------------------
  logic invalid_ff;
  logic nxt_invalid;

  always_comb begin
    nxt_invalid = invalid_ff;
    if (alertClr) begin
      nxt_invalid = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (badFaultWr) begin
      nxt_invalid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      invalid_ff <= 1'b0;
    end else begin
      invalid_ff <= nxt_invalid;
    end
  end

  assign cmlInvalidData = invalid_ff;
  assign statusWordCml = invalid_ff;
  assign alertOutputPin = invalid_ff;

  // ----------------------------------------------------------------
  // Commit to NVM
  // ----------------------------------------------------------------
  // The snapshot is the image as it stands when the command lands
  logic store_ff;
  logic nxt_store;
  pmbtf_pkg::pmbtf_image_s storeImg_ff;
  pmbtf_pkg::pmbtf_image_s nxt_storeImg;

  always_comb begin
    nxt_store = running && storeAll;
    nxt_storeImg = storeImg_ff;
    if (running && storeAll) begin
      nxt_storeImg = cfg_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      store_ff <= 1'b0;
      storeImg_ff <= pmbtf_pkg::IMAGE_RST;
    end else begin
      store_ff <= nxt_store;
      storeImg_ff <= nxt_storeImg;
    end
  end

  assign nvmStore = store_ff;
  assign nvmImageOut = storeImg_ff;

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  pmbtf_pkg::pmbtf_tune_s tuneA_ff;
  pmbtf_pkg::pmbtf_tune_s tuneB_ff;
  pmbtf_pkg::pmbtf_tune_s nxt_tuneA;
  pmbtf_pkg::pmbtf_tune_s nxt_tuneB;
  logic [7:0] iinMax_ff;
  logic boost_ff;
  logic signed [5:0] ofs_ff;
  logic [7:0] nxt_iinMax;
  logic nxt_boost;
  logic signed [5:0] nxt_ofs;

  always_comb begin
    nxt_tuneA = pmbtf_pkg::decodeChan(cfg_ff.chA);
    nxt_tuneB = pmbtf_pkg::decodeChan(cfg_ff.chB);
    // Level 2 exists on channel A only
    nxt_tuneB.usr2Off = 1'b1;
    nxt_tuneB.usr2Mv = 9'h000;
    nxt_iinMax = cfg_ff.inputCurrentMax;
    nxt_boost = cfg_ff.shuntGainBoost;
    // Codes 10h-1Fh are the negative half: a plain sign extension
    nxt_ofs = 6'(signed'(cfg_ff.inputOffsetCode));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tuneA_ff <= '0;
      tuneB_ff <= '0;
      iinMax_ff <= 8'h00;
      boost_ff <= 1'b0;
      ofs_ff <= 6'h00;
    end else begin
      tuneA_ff <= nxt_tuneA;
      tuneB_ff <= nxt_tuneB;
      iinMax_ff <= nxt_iinMax;
      boost_ff <= nxt_boost;
      ofs_ff <= nxt_ofs;
    end
  end

  assign tuneA = tuneA_ff;
  assign tuneB = tuneB_ff;
  assign inputCurrentMax = iinMax_ff;
  assign shuntGainBoost = boost_ff;
  assign inputOffsetDeciAmp = ofs_ff;

  // ----------------------------------------------------------------
  // Load line lookup, one table per channel
  // ----------------------------------------------------------------
  pmbtf_ac_load_line_bin_rom u_acllA (
    .clk(clk),
    .nrst(nrst),
    .bin(cfg_ff.chA.acLoadLineBin),
    .loadLineUohm10(acLoadLineA)
  );

  pmbtf_ac_load_line_bin_rom u_acllB (
    .clk(clk),
    .nrst(nrst),
    .bin(cfg_ff.chB.acLoadLineBin),
    .loadLineUohm10(acLoadLineB)
  );

endmodule // pmbtf_regs
`default_nettype wire

// ===== pmbtf_regs_checker.sv
// Concurrent checks on the tuning and fault register bank
`timescale 1ns/1ns
`default_nettype none
module pmbtf_regs_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdPage,
  input wire logic [15:0] wrData,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic storeAll,
  input wire logic nvmStore,
  input wire logic alertClr,
  input wire logic alertOutputPin,
  input wire logic cmlInvalidData,
  input wire logic statusWordCml
);
  // First edge after reset loads the image and takes no command
  logic ldDone_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) ldDone_ff <= 1'b0;
    else ldDone_ff <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  read_answer_a: assert property (
    cmdValid && !cmdWrite && ldDone_ff |=> rdValid)
    else $error("read strobe got no rdValid");
  no_spur_read_a: assert property (
    rdValid |-> $past(cmdValid) && !$past(cmdWrite))
    else $error("rdValid without a read strobe");
  bad_write_a: assert property (
    cmdValid && cmdWrite && ldDone_ff && cmdCode == pmbtf_pkg::CMD_FAULT
    && wrData[7:0] != 8'h00 |=> alertOutputPin && cmlInvalidData)
    else $error("invalid fault write not flagged");
  flags_agree_a: assert property (
    alertOutputPin == cmlInvalidData && alertOutputPin == statusWordCml)
    else $error("alert and status flags disagree");
  flags_sticky_a: assert property (
    alertOutputPin && !alertClr |=> alertOutputPin)
    else $error("alert dropped without clear");
  alert_cause_a: assert property (
    $rose(alertOutputPin) |-> $past(cmdValid) && $past(cmdWrite)
    && $past(cmdCode) == pmbtf_pkg::CMD_FAULT)
    else $error("alert raised without a fault write");
  store_pulse_a: assert property (
    storeAll && ldDone_ff |=> nvmStore)
    else $error("store command gave no nvmStore");
  store_cause_a: assert property (nvmStore |-> $past(storeAll))
    else $error("nvmStore without store command");
  fault_resv_a: assert property (
    rdValid && $past(cmdCode) == pmbtf_pkg::CMD_FAULT |-> rdData[7:6] == 2'h0)
    else $error("fault byte reserved bits set");
  pageb_undershoot_level2_code_a: assert property (
    rdValid && $past(cmdCode) == pmbtf_pkg::CMD_TRANS
    && $past(cmdPage) == pmbtf_pkg::PAGE_B |-> rdData[15:11] == 5'h00)
    else $error("channel B transient upper bits set");
  cover property (rdValid);
  cover property (nvmStore);
  cover property ($rose(alertOutputPin));
endmodule // pmbtf_regs_checker
bind pmbtf_regs pmbtf_regs_checker i_pmbtf_regs_checker (.*);
`default_nettype wire

// ===== pmbtf_host_model.sv
// Host-side model that issues register reads and writes
`timescale 1ns/1ns
`default_nettype none
module pmbtf_host_model (
  input wire logic clk,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdPage,
  output logic [15:0] wrData,
  input wire logic [15:0] rdData,
  input wire logic rdValid
);
  initial begin
    {cmdValid, cmdWrite} = 2'h0;
    {cmdCode, cmdPage, wrData} = 32'h0000_0000;
  end
  // Entered just after a rising edge; the strobe is taken on the next one
  task automatic access(input logic wr, input logic [7:0] code,
    input logic [7:0] page, input logic [15:0] data,
    output logic [15:0] rd, output logic gotAns);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdCode = code;
    cmdPage = page;
    wrData = data;
    @(posedge clk);
    #1;
    rd = rdData;
    gotAns = rdValid;
    cmdValid = 1'b0;
    // Released data is inverted so a stale value can never pass
    wrData = ~data;
  endtask
endmodule // pmbtf_host_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the tuning and fault register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, nrst, storeAll, faultEvtA, faultEvtB, alertClr, ans;
  logic cmdValid, cmdWrite, rdValid, nvmStore, shuntGainBoost;
  logic alertOutputPin, cmlInvalidData, statusWordCml;
  logic [7:0] cmdCode, cmdPage, inputCurrentMax;
  logic [15:0] wrData, rdData, rdw, d;
  logic [2:0] faultCodeA, faultCodeB;
  logic [14:0] acLoadLineA, acLoadLineB;
  logic signed [5:0] inputOffsetDeciAmp;
  pmbtf_pkg::pmbtf_image_s nvmImage, nvmImageOut;
  pmbtf_pkg::pmbtf_tune_s tuneA, tuneB;
  pmbtf_pkg::pmbtf_chan_s c;
  logic [15:0] expW [3][2];
  logic [31:0] seed = 32'h03E358A5;
  int fail_count = 0;
  int total_checks = 0;
  int ci, pg;
  localparam logic [15:0] GP [4] = '{16'h00C8, 16'h0064, 16'h0042, 16'h0032};
  localparam logic [15:0] AG [4] = '{16'h000A, 16'h000F, 16'h0014, 16'h0005};
  pmbtf_regs i_pmbtf_regs (.*);
  pmbtf_host_model i_pmbtf_host_model (.*);
  always #2 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] msk(input int ci, input int p);
    case (ci)
      0: return 16'h3FFF;
      1: return p ? 16'h07FF : 16'hF7FF;
      default: return p ? 16'h3FFF : 16'hFFFF;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic wr, input logic [7:0] code,
    input logic [7:0] page, input logic [15:0] dat);
    step();
    i_pmbtf_host_model.access(wr, code, page, dat, rdw, ans);
    check({15'h0, ans}, {15'h0, ~wr});
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    {clk, nrst, storeAll, faultEvtA, faultEvtB, alertClr} = 6'h00;
    {faultCodeA, faultCodeB} = 6'h00;
    nvmImage = pmbtf_pkg::pmbtf_image_s'(94'({rnd(), rnd(), rnd()}));
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    step();
    for (int p = 0; p < 2; p++) begin
      c = p ? nvmImage.chB : nvmImage.chA;
      expW[0][p] = {2'h0, c.intGain, c.integrationTimeCode,
        c.acPathGainCode, c.acLoadLineBin};
      expW[1][p] = msk(1, p) & {c.undershootLevel2Code, 1'b0,
        c.minOffTimeCode, c.blankingTimeCode, c.phaseAddLimit,
        c.transientHysteresisCode, c.undershootLevel1Code};
      expW[2][p][7:0] = c.outputCurrentMax;
    end
    expW[2][0][15:8] = nvmImage.inputCurrentMax;
    expW[2][1][15:8] = {2'h0, nvmImage.shuntGainBoost, nvmImage.inputOffsetCode};
    for (int n = 0; n < 46; n++) begin
      ci = n < 6 ? n / 2 : int'(rnd() % 3);
      pg = n < 6 ? n % 2 : int'(rnd() % 2);
      if (n >= 6) begin
        d = 16'(rnd());
        acc(1'b1, pmbtf_pkg::CMD_COMP + 8'(ci + (ci > 0)), 8'(pg), d);
        expW[ci][pg] = d & msk(ci, pg);
      end
      acc(1'b0, pmbtf_pkg::CMD_COMP + 8'(ci + (ci > 0)), 8'(pg), 16'h0000);
      check(rdw, expW[ci][pg]);
    end
    acc(1'b0, pmbtf_pkg::CMD_TRANS, 8'h02, 16'h0000);
    check(rdw, 16'h0000);
    $display("Test defaults and paged access done");
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, pmbtf_pkg::CMD_TRANS, pmbtf_pkg::PAGE_A,
        {1'b0, 3'(k), 1'b0, 2'(k), 3'(k), 1'(k), 2'(k), 3'(k)});
      step();
      check(16'(tuneA.minOffNs), 16'(45 + 15 * (k % 4)));
      check(16'(tuneA.blankNs), 16'(36 + 6 * k));
      check(16'(tuneA.phaseMax), 16'(3 + k % 2));
      check(16'(tuneA.hysMv), 16'(5 + 5 * (k % 4)));
      check({15'h0, tuneA.usr1Off}, 16'(k == 7));
      check({15'h0, tuneA.usr2Off}, 16'(k == 7));
      if (k < 7) check(16'(tuneA.usr1Mv), 16'(90 + 30 * k));
      if (k < 7) check(16'(tuneA.usr2Mv), 16'(140 + 40 * k));
    end
    check({15'h0, tuneB.usr2Off}, 16'h0001);
    for (int k = 0; k < 16; k++) begin
      acc(1'b1, pmbtf_pkg::CMD_COMP, pmbtf_pkg::PAGE_A,
        {2'h0, 2'(k), 4'(k), 2'(k), 6'(k)});
      step();
      check(16'(tuneA.intTcUs),
        16'(k < 8 ? 5 * (k + 1) : (k == 12 ? 5 : k - 7)));
      check(16'(tuneA.intGainPct), GP[k % 4]);
      check(16'(tuneA.acGainX10), AG[k % 4]);
    end
    acc(1'b1, pmbtf_pkg::CMD_COMP, pmbtf_pkg::PAGE_A, 16'h003F);
    acc(1'b1, pmbtf_pkg::CMD_COMP, pmbtf_pkg::PAGE_B, 16'h0001);
    repeat (2) step();
    check(16'(acLoadLineA), 16'h7A12);
    check(16'(acLoadLineB), 16'h04E2);
    acc(1'b1, pmbtf_pkg::CMD_CURR, pmbtf_pkg::PAGE_B, 16'h3005);
    acc(1'b1, pmbtf_pkg::CMD_CURR, pmbtf_pkg::PAGE_A, 16'hFF2A);
    step();
    check({10'h0, inputOffsetDeciAmp}, 16'h0030);
    check({7'h0, shuntGainBoost, inputCurrentMax}, 16'h01FF);
    check(16'(tuneA.ioutMaxAmp), 16'h002A);
    $display("Test decodes done");
    acc(1'b1, pmbtf_pkg::CMD_FAULT, 8'h00, 16'h0000);
    for (int k = 1; k < 8; k++) begin
      {faultEvtA, faultEvtB, faultCodeA, faultCodeB} = {2'b11, 3'(8 - k), 3'(k)};
      step();
      {faultEvtA, faultEvtB, faultCodeB} = {2'b01, ~3'(k)};
      step();
      {faultEvtA, faultEvtB} = 2'b00;
      acc(1'b0, pmbtf_pkg::CMD_FAULT, 8'(k), 16'h0000);
      check(rdw, {10'h000, 3'(8 - k), 3'(k)});
      acc(1'b1, pmbtf_pkg::CMD_FAULT, 8'h00, 16'h0000);
    end
    {faultEvtA, faultCodeA} = {1'b1, 3'h4};
    step();
    faultEvtA = 1'b0;
    acc(1'b1, pmbtf_pkg::CMD_FAULT, 8'h00, 16'h0005);
    check({13'h0, alertOutputPin, cmlInvalidData, statusWordCml}, 16'h0007);
    acc(1'b0, pmbtf_pkg::CMD_FAULT, 8'h00, 16'h0000);
    check(rdw, 16'h0020);
    alertClr = 1'b1;
    step();
    alertClr = 1'b0;
    check({15'h0, alertOutputPin}, 16'h0000);
    $display("Test fault record done");
    storeAll = 1'b1;
    step();
    storeAll = 1'b0;
    check({15'h0, nvmStore}, 16'h0001);
    check({5'h0, nvmImageOut.faultRecordChanA, nvmImageOut.inputCurrentMax},
      16'h04FF);
    acc(1'b1, pmbtf_pkg::CMD_FAULT, 8'h00, 16'h0000);
    storeAll = 1'b1;
    step();
    storeAll = 1'b0;
    check(16'(nvmImageOut.faultRecordChanA), 16'h0000);
    $display("Test store done");
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
